// *** shared/aarb_cfg.svh ***
// Register offsets, reset values and limits of the access arbiter
`ifndef AARB_CFG_SVH
`define AARB_CFG_SVH
`define AARB_OFS_CHANNEL_LOCK 16'h011c
`define AARB_OFS_RESTORE_CMD 16'h0404
`define AARB_OFS_PANEL_LOCK 16'h3a02
`define AARB_RST_CHANNEL_LOCK 16'h0000
`define AARB_RST_PANEL_LOCK 16'h0000
`define AARB_POS_MIN 32'hf0000000
`define AARB_POS_MAX 32'h0fffffff
`define AARB_UNITS_PER_REV 32'h00004000
`endif

// *** shared/aarb_pkg.sv ***
// Types shared by the access arbiter
package aarb_pkg;
  typedef enum logic [2:0] {
    AARB_CH_NONE = 3'h0,
    AARB_CH_PANEL = 3'h1,
    AARB_CH_TERMINAL = 3'h2,
    AARB_CH_TOOL = 3'h3,
    AARB_CH_FIELDBUS = 3'h4
  } aarb_chan_t;
  typedef enum logic [2:0] {
    AARB_RS_IDLE = 3'b001,
    AARB_RS_LOAD = 3'b010,
    AARB_RS_SAVE = 3'b100
  } aarb_rstate_t;
endpackage

// *** rtl/aarb_access_arbiter.sv ***
// Access arbiter, channel/panel locks, factory restore and jog range clamp
`timescale 1ns/10ps
`include "aarb_cfg.svh"

// Contract
// - Writing restore command value 1 reloads factory values then saves them; 0 does nothing.
// - Restore command reads nonzero while saving, zero when done; host polls.
// - Restore command write accepted only with power stage disabled.
// - Restored values take effect only after next power-up.
// - At most one channel holds exclusive access at any time.
// - After power-up no channel holds exclusive access.
// - Analog and pulse-train references are effective from power-up.
// - Analog and pulse-train references ignored while exclusive access is held.
// - Halt, fault reset, enable, limits, reference switch, safe torque off always act.
// - Tool gets exclusive access with its switch On, releases it at Off.
// - Jog or autotuning started from the panel gives the panel exclusive access.
// - Channel lock 0 allows other channels, 1 blocks all but current; clearing is immediate.
// - Setting the channel lock waits until the active operating mode terminates.
// - Panel lock 1 blocks panel parameter change, jog, autotune, fault reset.
// - In jog mode actual position is confined to -268435456 through 268435455 units.
// - Movement range limit applies only while jog mode is active.
// - Factory scaling counts 16384 user units per motor revolution.
module aarb_access_arbiter (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic par_wr_i,
  input wire logic par_rd_i,
  input wire logic [15:0] par_addr_i,
  input wire logic [15:0] par_wdata_i,
  input wire logic [2:0] par_chan_i,
  output logic [15:0] par_rdata_o,
  output logic par_ack_o,
  output logic par_err_o,
  input wire logic power_stage_en_i,
  input wire logic op_mode_active_i,
  input wire logic tool_excl_switch_i,
  input wire logic panel_jog_start_i,
  input wire logic panel_autotune_start_i,
  input wire logic panel_fault_reset_i,
  input wire logic panel_mode_end_i,
  input wire logic nv_save_done_i,
  output logic factory_load_o,
  output logic nv_save_start_o,
  output logic [2:0] excl_owner_o,
  output logic [2:0] lock_owner_o,
  output logic panel_start_jog_o,
  output logic panel_start_autotune_o,
  output logic panel_fault_reset_o,
  output logic panel_param_wr_ok_o,
  input wire logic [15:0] analog_ref_i,
  input wire logic [31:0] pulse_train_input_i,
  output logic [15:0] analog_ref_o,
  output logic [31:0] pulse_train_ref_o,
  input wire logic halt_in_i,
  input wire logic fault_reset_in_i,
  input wire logic enable_in_i,
  input wire logic positive_limit_input_i,
  input wire logic negative_limit_input_i,
  input wire logic ref_switch_in_i,
  input wire logic safe_torque_off_a_i,
  input wire logic safe_torque_off_b_i,
  output logic [7:0] io_func_o,
  input wire logic jog_active_i,
  input wire logic signed [31:0] pos_demand_i,
  output logic signed [31:0] pos_actual_o,
  output logic [31:0] units_per_rev_o
);

  // ------------------------------------------------------------
  // Pin synchronisers for the input functions
  // ------------------------------------------------------------
  logic [7:0] io_raw;
  logic [7:0] io_s1;
  logic [7:0] io_s2;
  logic [7:0] next_io_s1;
  logic [7:0] next_io_s2;
  logic [7:0] next_io_func;

  assign io_raw = {safe_torque_off_b_i, safe_torque_off_a_i, ref_switch_in_i, negative_limit_input_i,
                   positive_limit_input_i, enable_in_i, fault_reset_in_i, halt_in_i};

  always_comb
  begin
    next_io_s1 = io_raw;
    next_io_s2 = io_s1;
    next_io_func = io_s2; // Never gated by exclusive access
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      io_func_o <= 8'h00;
    end
    else
    begin
      io_s1 <= next_io_s1;
      io_s2 <= next_io_s2;
      io_func_o <= next_io_func;
    end
  end

  // ------------------------------------------------------------
  // Register access, locks and restore sequencer
  // ------------------------------------------------------------
  logic [15:0] channel_lock;
  logic [15:0] panel_lock;
  logic lock_pending;
  aarb_pkg::aarb_rstate_t rstate;
  aarb_pkg::aarb_chan_t excl;
  aarb_pkg::aarb_chan_t lock_own;
  logic [15:0] next_channel_lock;
  logic [15:0] next_panel_lock;
  logic next_lock_pending;
  aarb_pkg::aarb_rstate_t next_rstate;
  aarb_pkg::aarb_chan_t next_excl;
  aarb_pkg::aarb_chan_t next_lock_own;
  logic [15:0] next_rdata;
  logic next_ack;
  logic next_err;
  logic val_ok;
  logic blocked;
  logic panel_ok;

  assign val_ok = (par_wdata_i == 16'h0000) || (par_wdata_i == 16'h0001);
  // A locked channel lets only its owner write; reads from any channel still pass
  assign blocked = channel_lock[0] && (par_chan_i != lock_own);
  assign panel_ok = !panel_lock[0] && !(channel_lock[0] && lock_own != aarb_pkg::AARB_CH_PANEL);

  always_comb
  begin
    next_channel_lock = channel_lock;
    next_panel_lock = panel_lock;
    next_lock_pending = lock_pending;
    next_rstate = rstate;
    next_excl = excl;
    next_lock_own = lock_own;
    next_rdata = par_rdata_o;
    next_ack = 1'b0;
    next_err = 1'b0;
    // Exclusive owner is a single encoded value, so two owners cannot exist
    if (tool_excl_switch_i && excl == aarb_pkg::AARB_CH_NONE)
      next_excl = aarb_pkg::AARB_CH_TOOL;
    else if (!tool_excl_switch_i && excl == aarb_pkg::AARB_CH_TOOL)
      next_excl = aarb_pkg::AARB_CH_NONE;
    if (excl == aarb_pkg::AARB_CH_NONE && panel_ok && (panel_jog_start_i || panel_autotune_start_i))
      next_excl = aarb_pkg::AARB_CH_PANEL;
    else if (excl == aarb_pkg::AARB_CH_PANEL && panel_mode_end_i)
      next_excl = aarb_pkg::AARB_CH_NONE;
    // Deferred lock lands once the running mode has ended
    if (lock_pending && !op_mode_active_i)
    begin
      next_channel_lock = 16'h0001;
      next_lock_pending = 1'b0;
    end
    case (rstate)
      aarb_pkg::AARB_RS_IDLE:
        next_rstate = aarb_pkg::AARB_RS_IDLE;
      aarb_pkg::AARB_RS_LOAD:
        next_rstate = aarb_pkg::AARB_RS_SAVE; // Load and save start together in LOAD; SAVE waits for save done
      aarb_pkg::AARB_RS_SAVE:
        if (nv_save_done_i)
          next_rstate = aarb_pkg::AARB_RS_IDLE;
      default:
        next_rstate = aarb_pkg::AARB_RS_IDLE;
    endcase
    if (par_wr_i)
    begin
      next_ack = 1'b1;
      if (!val_ok || blocked)
        next_err = 1'b1;
      else if (par_addr_i == `AARB_OFS_CHANNEL_LOCK)
      begin
        if (par_wdata_i[0] && op_mode_active_i)
          next_lock_pending = 1'b1;
        else
        begin
          next_channel_lock = par_wdata_i; // Immediate
          next_lock_pending = 1'b0;
        end
        if (par_wdata_i[0])
          next_lock_own = aarb_pkg::aarb_chan_t'(par_chan_i);
      end
      else if (par_addr_i == `AARB_OFS_PANEL_LOCK)
        next_panel_lock = par_wdata_i;
      else if (par_addr_i == `AARB_OFS_RESTORE_CMD)
      begin
        if (power_stage_en_i || rstate != aarb_pkg::AARB_RS_IDLE)
          next_err = 1'b1;
        else if (par_wdata_i[0])
          next_rstate = aarb_pkg::AARB_RS_LOAD;
      end
      else
        next_err = 1'b1;
    end
    else if (par_rd_i)
    begin
      next_ack = 1'b1;
      if (par_addr_i == `AARB_OFS_CHANNEL_LOCK)
        next_rdata = channel_lock;
      else if (par_addr_i == `AARB_OFS_PANEL_LOCK)
        next_rdata = panel_lock;
      else if (par_addr_i == `AARB_OFS_RESTORE_CMD)
        next_rdata = {15'h0000, rstate != aarb_pkg::AARB_RS_IDLE};
      else
      begin
        next_rdata = 16'h0000;
        next_err = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      channel_lock <= `AARB_RST_CHANNEL_LOCK;
      panel_lock <= `AARB_RST_PANEL_LOCK;
      lock_pending <= 1'b0;
      rstate <= aarb_pkg::AARB_RS_IDLE;
      excl <= aarb_pkg::AARB_CH_NONE;
      lock_own <= aarb_pkg::AARB_CH_NONE;
      par_rdata_o <= 16'h0000;
      par_ack_o <= 1'b0;
      par_err_o <= 1'b0;
    end
    else
    begin
      channel_lock <= next_channel_lock;
      panel_lock <= next_panel_lock;
      lock_pending <= next_lock_pending;
      rstate <= next_rstate;
      excl <= next_excl;
      lock_own <= next_lock_own;
      par_rdata_o <= next_rdata;
      par_ack_o <= next_ack;
      par_err_o <= next_err;
    end
  end

  // Restore only writes the store; the running set is reloaded at power-up
  assign factory_load_o = (rstate == aarb_pkg::AARB_RS_LOAD);
  assign nv_save_start_o = (rstate == aarb_pkg::AARB_RS_LOAD);
  assign excl_owner_o = excl;
  assign lock_owner_o = channel_lock[0] ? lock_own : aarb_pkg::AARB_CH_NONE;
  assign panel_start_jog_o = panel_jog_start_i && panel_ok;
  assign panel_start_autotune_o = panel_autotune_start_i && panel_ok;
  assign panel_fault_reset_o = panel_fault_reset_i && panel_ok;
  assign panel_param_wr_ok_o = panel_ok;

  // ------------------------------------------------------------
  // Reference gating and movement range
  // ------------------------------------------------------------
  logic [15:0] next_analog;
  logic [31:0] next_pti;
  logic signed [31:0] next_pos;

  always_comb
  begin
    // Pass from power-up, drop to zero under exclusive access
    next_analog = (excl == aarb_pkg::AARB_CH_NONE) ? analog_ref_i : 16'h0000;
    next_pti = (excl == aarb_pkg::AARB_CH_NONE) ? pulse_train_input_i : 32'h00000000;
    next_pos = pos_demand_i;
    if (jog_active_i)
    begin
      if (pos_demand_i < $signed(`AARB_POS_MIN))
        next_pos = $signed(`AARB_POS_MIN);
      else if (pos_demand_i > $signed(`AARB_POS_MAX))
        next_pos = $signed(`AARB_POS_MAX);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      analog_ref_o <= 16'h0000;
      pulse_train_ref_o <= 32'h00000000;
      pos_actual_o <= 32'sh00000000;
    end
    else
    begin
      analog_ref_o <= next_analog;
      pulse_train_ref_o <= next_pti;
      pos_actual_o <= next_pos;
    end
  end

  assign units_per_rev_o = `AARB_UNITS_PER_REV;

endmodule

// *** bench/aarb_checker.sv ***
// Port checker of the access arbiter
`timescale 1ns/10ps
module aarb_checker (
  input wire logic sys_clk_i, rst_b_i, par_wr_i, par_err_o, power_stage_en_i, factory_load_o,
  input wire logic tool_excl_switch_i, jog_active_i, panel_param_wr_ok_o,
  input wire logic panel_start_jog_o, panel_start_autotune_o, panel_fault_reset_o,
  input wire logic [15:0] par_addr_i, par_wdata_i, analog_ref_i, analog_ref_o,
  input wire logic [2:0] excl_owner_o,
  input wire logic signed [31:0] pos_demand_i, pos_actual_o,
  input wire logic [31:0] units_per_rev_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire rs_wr = par_wr_i && par_addr_i == 16'h0404;
  wire any_wr = rs_wr || par_wr_i && (par_addr_i == 16'h011c || par_addr_i == 16'h3a02);
  a_owner_reset: assert property ($rose(rst_b_i) |-> excl_owner_o == 3'h0) else $error("owner after reset");
  a_restore_refused: assert property (rs_wr && power_stage_en_i |=> par_err_o && !factory_load_o)
    else $error("restore taken with power on");
  a_restore_zero: assert property (rs_wr && par_wdata_i == 16'h0 |=> !factory_load_o) else $error("restore on 0");
  a_restore_start: assert property (rs_wr && par_wdata_i == 16'h1 && !power_stage_en_i |=> par_err_o || factory_load_o)
    else $error("restore not started");
  a_bad_value: assert property (any_wr && par_wdata_i > 16'h1 |=> par_err_o) else $error("bad value taken");
  a_refs_gated: assert property (excl_owner_o != 3'h0 && $past(excl_owner_o) != 3'h0 |-> analog_ref_o == 16'h0)
    else $error("reference passed");
  a_refs_pass: assert property (excl_owner_o == 3'h0 && $past(excl_owner_o) == 3'h0 && $past(rst_b_i)
    |-> analog_ref_o == $past(analog_ref_i)) else $error("reference lost");
  a_jog_clamp: assert property (jog_active_i |=> pos_actual_o >= -32'sd268435456 && pos_actual_o <= 32'sd268435455)
    else $error("position out of range");
  a_free_pos: assert property (!jog_active_i |=> pos_actual_o == $past(pos_demand_i)) else $error("clamped");
  a_units_const: assert property (units_per_rev_o == 32'h00004000) else $error("units per rev");
  a_tool_release: assert property ($fell(tool_excl_switch_i) && excl_owner_o == 3'h3 |-> ##[1:2] excl_owner_o == 3'h0)
    else $error("tool kept access");
  a_panel_locked: assert property (!panel_param_wr_ok_o |-> !(panel_start_jog_o || panel_start_autotune_o ||
    panel_fault_reset_o)) else $error("locked panel acted");
  c_restore: cover property (factory_load_o);
  c_tool: cover property (excl_owner_o == 3'h3);
  c_clamp: cover property (jog_active_i && pos_demand_i > 32'sd268435455);
endmodule
bind aarb_access_arbiter aarb_checker aarb_checker_i (.sys_clk_i, .rst_b_i, .par_wr_i, .par_err_o, .power_stage_en_i,
  .factory_load_o, .tool_excl_switch_i, .jog_active_i, .panel_param_wr_ok_o, .panel_start_jog_o,
  .panel_start_autotune_o, .panel_fault_reset_o, .par_addr_i, .par_wdata_i, .analog_ref_i, .analog_ref_o,
  .excl_owner_o, .pos_demand_i, .pos_actual_o, .units_per_rev_o);

// *** bench/aarb_nv_model.sv ***
// Nonvolatile store model, finishing saves alternately slow and prompt
`timescale 1ns/10ps
module aarb_nv_model #(parameter int SLOW = 20) (
  input wire logic sys_clk_i,
  input wire logic nv_save_start_i,
  output logic nv_save_done_o = 1'b0
);
  int cnt = 0;
  bit slow = 1'b1;
  always @(posedge sys_clk_i)
  begin
    nv_save_done_o <= cnt == 1;
    cnt <= nv_save_start_i ? (slow ? SLOW : 1) : (cnt > 0 ? cnt - 1 : 0);
    if (nv_save_start_i)
      slow <= !slow;
  end
endmodule

// *** bench/tb_aarb_access_arbiter.sv ***
// Self-checking bench of the access arbiter
`timescale 1ns/10ps
module tb_aarb_access_arbiter;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, par_wr_i = 1'b0, par_rd_i = 1'b0, power_stage_en_i = 1'b0;
  logic op_mode_active_i = 1'b0, tool_excl_switch_i = 1'b0, jog_active_i = 1'b0, panel_mode_end_i = 1'b0;
  logic panel_jog_start_i = 1'b0, panel_autotune_start_i = 1'b0, panel_fault_reset_i = 1'b0;
  logic par_ack_o, par_err_o, factory_load_o, nv_save_start_o, nv_save_done_i, bus_err;
  logic [1:0] bus_load;
  logic panel_start_jog_o, panel_start_autotune_o, panel_fault_reset_o, panel_param_wr_ok_o;
  logic [15:0] par_addr_i = 16'h0, par_wdata_i = 16'h0, analog_ref_i = 16'h0, par_rdata_o, analog_ref_o, bus_data;
  logic [2:0] par_chan_i = 3'h4, excl_owner_o, lock_owner_o;
  logic [31:0] pulse_train_input_i = 32'h0, pulse_train_ref_o, units_per_rev_o;
  logic [7:0] pins = 8'h0, io_func_o;
  logic signed [31:0] pos_demand_i = 32'sh0, pos_actual_o;
  logic [31:0] pv [4] = '{32'hf0000000, 32'hefffffff, 32'h0fffffff, 32'h10000000};
  int err_count = 0, n_tests = 0;
  aarb_access_arbiter aarb_access_arbiter_i (.sys_clk_i, .rst_b_i, .par_wr_i, .par_rd_i, .par_addr_i, .par_wdata_i,
    .par_chan_i, .par_rdata_o, .par_ack_o, .par_err_o, .power_stage_en_i, .op_mode_active_i, .tool_excl_switch_i,
    .panel_jog_start_i, .panel_autotune_start_i, .panel_fault_reset_i, .panel_mode_end_i, .nv_save_done_i,
    .factory_load_o, .nv_save_start_o, .excl_owner_o, .lock_owner_o, .panel_start_jog_o, .panel_start_autotune_o,
    .panel_fault_reset_o, .panel_param_wr_ok_o, .analog_ref_i, .pulse_train_input_i, .analog_ref_o, .pulse_train_ref_o,
    .halt_in_i(pins[0]), .fault_reset_in_i(pins[1]), .enable_in_i(pins[2]), .positive_limit_input_i(pins[3]),
    .negative_limit_input_i(pins[4]), .ref_switch_in_i(pins[5]), .safe_torque_off_a_i(pins[6]),
    .safe_torque_off_b_i(pins[7]), .io_func_o, .jog_active_i, .pos_demand_i, .pos_actual_o, .units_per_rev_o);
  aarb_nv_model aarb_nv_model_i (.sys_clk_i, .nv_save_start_i(nv_save_start_o), .nv_save_done_o(nv_save_done_i));
  always #10 sys_clk_i = ~sys_clk_i;
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // One-cycle strobe; the registered ack and error stand only in the cycle after the taking edge
  task automatic bus(input logic wr, input logic [15:0] a, d, input logic [2:0] ch);
    par_wr_i = wr;
    par_rd_i = !wr;
    par_addr_i = a;
    par_wdata_i = d;
    par_chan_i = ch;
    tick(1);
    chk("ack", par_ack_o, 1'b1);
    bus_err = par_err_o;
    bus_data = par_rdata_o;
    bus_load = {factory_load_o, nv_save_start_o};
    par_wr_i = 1'b0;
    par_rd_i = 1'b0;
    tick(1);
  endtask
  function automatic logic [31:0] exp_pos(input logic jog, input logic signed [31:0] d);
    if (jog && d < -32'sd268435456)
      return 32'hf0000000;
    if (jog && d > 32'sd268435455)
      return 32'h0fffffff;
    return d;
  endfunction
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge sys_clk_i);
    err_count++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(97001));
    tick(4);
    rst_b_i = 1'b1;
    chk("owner", excl_owner_o, 3'h0);
    bus(0, 16'h011c, 16'h0, 3'h4);
    chk("chlock", bus_data, 16'h0);
    bus(0, 16'h3a02, 16'h0, 3'h4);
    chk("pnlock", bus_data, 16'h0);
    bus(0, 16'h0200, 16'h0, 3'h4);
    chk("unmapped", bus_err, 1'b1);
    for (int i = 0; i < 24; i++)
    begin
      analog_ref_i = 16'($urandom);
      pulse_train_input_i = $urandom;
      pins = 8'($urandom);
      jog_active_i = i < 4 ? 1'b1 : 1'($urandom);
      pos_demand_i = i < 4 ? pv[i] : $urandom;
      tick(4);
      chk("aref", analog_ref_o, analog_ref_i);
      chk("ptref", pulse_train_ref_o, pulse_train_input_i);
      chk("pins", io_func_o, pins);
      chk("pos", pos_actual_o, exp_pos(jog_active_i, pos_demand_i));
    end
    jog_active_i = 1'b0;
    power_stage_en_i = 1'b1;
    bus(1, 16'h0404, 16'h1, 3'h4);
    chk("rs_on", bus_err, 1'b1);
    chk("rs_on_ld", bus_load, 2'h0);
    power_stage_en_i = 1'b0;
    bus(1, 16'h0404, 16'h2, 3'h4);
    chk("rs_bad", bus_err, 1'b1);
    bus(1, 16'h0404, 16'h0, 3'h4);
    chk("rs_zero", bus_load, 2'h0);
    bus(1, 16'h3a02, 16'h1, 3'h4);
    for (int k = 0; k < 2; k++)
    begin
      bus(1, 16'h0404, 16'h1, 3'h4);
      chk("rs_load", bus_load, 2'h3);
      bus(0, 16'h0404, 16'h0, 3'h4);
      chk("rs_busy", bus_data != 16'h0, 1'b1);
      for (int p = 0; p < 40 && bus_data !== 16'h0; p++)
        bus(0, 16'h0404, 16'h0, 3'h4);
      chk("rs_done", bus_data, 16'h0);
    end
    bus(0, 16'h3a02, 16'h0, 3'h4);
    chk("keep", bus_data, 16'h1);
    {panel_jog_start_i, panel_autotune_start_i, panel_fault_reset_i} = 3'h7;
    #1 chk("lk_out", {panel_start_jog_o, panel_start_autotune_o, panel_fault_reset_o}, 3'h0);
    chk("lk_wr", panel_param_wr_ok_o, 1'b0);
    tick(1);
    {panel_jog_start_i, panel_autotune_start_i, panel_fault_reset_i} = 3'h0;
    chk("lk_own", excl_owner_o, 3'h0);
    bus(1, 16'h3a02, 16'h0, 3'h4);
    {panel_autotune_start_i, panel_fault_reset_i} = 2'h3;
    #1 chk("ul_out", {panel_start_autotune_o, panel_fault_reset_o}, 2'h3);
    tick(1);
    {panel_autotune_start_i, panel_fault_reset_i} = 2'h0;
    chk("panel", excl_owner_o, 3'h1);
    panel_mode_end_i = 1'b1;
    tick(1);
    panel_mode_end_i = 1'b0;
    tool_excl_switch_i = 1'b1;
    tick(2);
    chk("tool", excl_owner_o, 3'h3);
    panel_jog_start_i = 1'b1;
    analog_ref_i = 16'($urandom) | 16'h1;
    pulse_train_input_i = $urandom | 32'h1;
    tick(1);
    panel_jog_start_i = 1'b0;
    tick(1);
    chk("one", excl_owner_o, 3'h3);
    chk("gated", analog_ref_o, 16'h0);
    chk("gated_pt", pulse_train_ref_o, 32'h0);
    tool_excl_switch_i = 1'b0;
    tick(2);
    chk("free", excl_owner_o, 3'h0);
    op_mode_active_i = 1'b1;
    bus(1, 16'h011c, 16'h1, 3'h4);
    chk("cl_wait", lock_owner_o, 3'h0);
    op_mode_active_i = 1'b0;
    tick(2);
    chk("cl_own", lock_owner_o, 3'h4);
    bus(1, 16'h3a02, 16'h0, 3'h2);
    chk("cl_blk", bus_err, 1'b1);
    bus(1, 16'h011c, 16'h0, 3'h4);
    chk("cl_off", lock_owner_o, 3'h0);
    chk("upr", units_per_rev_o, 32'h00004000);
    wrap_up();
  end
endmodule
